// ===== core/qp_bus_map.svh
// Constants for the quad-pumped data phase controller
`ifndef QP_BUS_MAP_SVH
`define QP_BUS_MAP_SVH
`define QP_GROUPS 4
`define QP_GROUP_W 16
`define QP_DATA_W 64
`define QP_BEATS 4
`define QP_RESET_CLKS 2
`define QP_LINK_CLK_DIV 4
`endif

// ===== core/qp_bus_pkg.sv
// Types for the quad-pumped data phase controller
package qp_bus_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DRIVE,
		ST_GAP
	} tx_state_t;
endpackage

// ===== core/qp_group_lane.sv
// One 16-bit data group: inversion choice, parity and receive decode
`timescale 1ns/1ps
`include "qp_bus_map.svh"
module qp_group_lane #(
	parameter int W = `QP_GROUP_W
) (
	input wire logic [W-1:0] i_word,
	input wire logic [W-1:0] i_prev_wire,
	input wire logic [W-1:0] i_rx_wire,
	input wire logic i_rx_inv,
	output logic [W-1:0] o_tx_wire,
	output logic o_tx_inv,
	output logic o_tx_par,
	output logic [W-1:0] o_rx_word,
	output logic o_rx_par
);
	wire logic [W-1:0] change_mask;
	logic [$clog2(W+1)-1:0] change_cnt;
	wire logic do_inv;
	assign change_mask = i_word ^ i_prev_wire;
	always_comb begin
		change_cnt = '0;
		for (int k = 0; k < W; k++) begin
			change_cnt = change_cnt + {{($clog2(W+1)-1){1'b0}}, change_mask[k]};
		end
	end
	// Invert when more than half of the group would toggle
	assign do_inv = change_cnt > ($clog2(W+1))'(W / 2);
	assign o_tx_wire = do_inv ? ~i_word : i_word;
	assign o_tx_inv = do_inv;
	// Parity over driven wires, high when the count of low lines is even
	assign o_tx_par = ~^{o_tx_wire, ~o_tx_inv} ^ 1'b0;
	assign o_rx_par = ~^{i_rx_wire, ~i_rx_inv};
	assign o_rx_word = i_rx_inv ? ~i_rx_wire : i_rx_wire;
endmodule

// ===== core/qp_bus_host.sv
// Data-phase and snoop-result controller for the shared bus
`timescale 1ns/1ps
`include "qp_bus_map.svh"
// Operation
// - Sixty-four data lines in four groups
// - Four transfers per bus clock
// - Capture on falling edges of both strobes
// - Group n uses strobe pair and flag n
// - Flagged group is inverted on wires
// - Invert when over half bits toggle
// - Data valid on each valid transfer
// - Hold busy while driving data
// - Addressed agent drives defer input
// - Data driver also drives parity
// - Hit plus dirty hit means stall
// - Snoop lines driven, sampled on edges
// - Snoop, defer and burst start timed to the bus clock
module qp_bus_host #(
	parameter int GROUPS = `QP_GROUPS,
	parameter int GW = `QP_GROUP_W,
	parameter int DIV = `QP_LINK_CLK_DIV
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [GROUPS*GW-1:0] i_tx_data,
	input wire logic i_tx_valid,
	input wire logic i_tx_last,
	output logic o_tx_ready,
	output logic [GROUPS*GW-1:0] o_rx_data,
	output logic o_rx_valid,
	output logic [GROUPS-1:0] o_rx_par_err,
	input wire logic i_snoop_hit_req,
	input wire logic i_snoop_dirty_req,
	output logic o_snoop_hit,
	output logic o_snoop_dirty,
	output logic o_snoop_stall,
	output logic o_defer,
	output logic o_bus_clk,
	output logic [GROUPS*GW-1:0] o_data_out,
	output logic o_data_oe,
	input wire logic [GROUPS*GW-1:0] i_data_in,
	output logic [GROUPS-1:0] o_inv_out,
	input wire logic [GROUPS-1:0] i_inv_in,
	output logic [GROUPS-1:0] o_par_out,
	input wire logic [GROUPS-1:0] i_par_in,
	output logic [GROUPS-1:0] o_stb_pos_out,
	output logic [GROUPS-1:0] o_stb_neg_out,
	input wire logic [GROUPS-1:0] i_stb_pos_in,
	input wire logic [GROUPS-1:0] i_stb_neg_in,
	output logic o_valid_out,
	output logic o_valid_oe,
	input wire logic i_valid_in,
	output logic o_held_out,
	output logic o_held_oe,
	input wire logic i_held_in,
	output logic o_hit_out,
	output logic o_hit_oe,
	input wire logic i_hit_in,
	output logic o_dirty_out,
	output logic o_dirty_oe,
	input wire logic i_dirty_in,
	input wire logic i_defer_in
);
	localparam int DW = GROUPS * GW;
	localparam int CW = $clog2(DIV);
	// Bus clock divider; one beat enable per quarter period
	logic [CW-1:0] div_reg;
	wire logic [CW-1:0] div_next;
	wire logic beat_en;
	wire logic bclk_rise;
	assign div_next = div_reg + CW'(1);
	assign beat_en = 1'b1;
	assign bclk_rise = (div_reg == '0);
	always_ff @(posedge i_clk) begin
		if (i_rst) div_reg <= '0;
		else div_reg <= div_next;
	end
	assign o_bus_clk = (div_reg < CW'(DIV / 2));
	// Transmit path
	qp_bus_pkg::tx_state_t st_reg;
	qp_bus_pkg::tx_state_t st_next;
	logic [DW-1:0] prev_wire_reg;
	logic [DW-1:0] data_out_reg;
	logic [GROUPS-1:0] inv_reg;
	logic [GROUPS-1:0] par_reg;
	logic [GROUPS-1:0] stb_pos_reg;
	logic [GROUPS-1:0] stb_neg_reg;
	logic drive_reg;
	logic valid_reg;
	logic [1:0] beat_reg;
	wire logic [DW-1:0] tx_wire;
	wire logic [GROUPS-1:0] tx_inv;
	wire logic [GROUPS-1:0] tx_par;
	wire logic [DW-1:0] rx_word;
	wire logic [GROUPS-1:0] rx_par;
	wire logic take;
	// Synchronised pin inputs
	logic [DW-1:0] d_s1_reg, d_s2_reg;
	logic [GROUPS-1:0] inv_s1_reg, inv_s2_reg, par_s1_reg, par_s2_reg;
	logic [GROUPS-1:0] sp_s1_reg, sp_s2_reg, sp_s3_reg;
	logic [GROUPS-1:0] sn_s1_reg, sn_s2_reg, sn_s3_reg;
	logic [4:0] misc_s1_reg, misc_s2_reg;
	// Parity seen on the driven wires, for the checks below
	wire logic [GROUPS-1:0] par_seen;
	genvar g;
	generate
		for (g = 0; g < GROUPS; g++) begin : gen_lane
			// Group g maps to strobe pair g and flag g
			qp_group_lane #(.W(GW)) u_lane (
				.i_word(i_tx_data[g*GW +: GW]),
				.i_prev_wire(prev_wire_reg[g*GW +: GW]),
				.i_rx_wire(d_s2_reg[g*GW +: GW]),
				.i_rx_inv(inv_s2_reg[g]),
				.o_tx_wire(tx_wire[g*GW +: GW]),
				.o_tx_inv(tx_inv[g]),
				.o_tx_par(tx_par[g]),
				.o_rx_word(rx_word[g*GW +: GW]),
				.o_rx_par(rx_par[g])
			);
			assign par_seen[g] = ^{o_data_out[g*GW +: GW], o_inv_out[g]};
		end
	endgenerate
	// Bus is free when nobody else holds it
	wire logic bus_free;
	assign bus_free = ~misc_s2_reg[1];
	assign take = (st_reg == qp_bus_pkg::ST_DRIVE) && i_tx_valid && beat_en;
	assign o_tx_ready = take;
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			qp_bus_pkg::ST_IDLE: if (i_tx_valid && bus_free && bclk_rise) st_next = qp_bus_pkg::ST_DRIVE;
			qp_bus_pkg::ST_DRIVE: if (take && i_tx_last) st_next = qp_bus_pkg::ST_GAP;
			qp_bus_pkg::ST_GAP: st_next = qp_bus_pkg::ST_IDLE;
			default: st_next = qp_bus_pkg::ST_IDLE;
		endcase
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= qp_bus_pkg::ST_IDLE;
			drive_reg <= 1'b0;
			valid_reg <= 1'b0;
			beat_reg <= 2'h0;
		end else begin
			st_reg <= st_next;
			// Busy also covers the cycle that shows the last beat on the wires
			drive_reg <= (st_next == qp_bus_pkg::ST_DRIVE) || take;
			valid_reg <= take;
			if (take) beat_reg <= beat_reg + 2'h1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			// Idle bus reads as every line deasserted
			prev_wire_reg <= '0;
			data_out_reg <= '0;
			inv_reg <= '0;
			par_reg <= '0;
			stb_pos_reg <= '0;
			stb_neg_reg <= '0;
		end else if (take) begin
			prev_wire_reg <= tx_wire;
			data_out_reg <= tx_wire;
			inv_reg <= tx_inv;
			par_reg <= tx_par;
			// Alternate strobes so each beat owns one falling edge
			stb_pos_reg <= beat_reg[0] ? '0 : '1;
			stb_neg_reg <= beat_reg[0] ? '1 : '0;
		end else begin
			stb_pos_reg <= '0;
			stb_neg_reg <= '0;
		end
	end
	assign o_data_out = data_out_reg;
	assign o_data_oe = drive_reg;
	assign o_inv_out = inv_reg;
	assign o_par_out = par_reg;
	assign o_stb_pos_out = stb_pos_reg;
	assign o_stb_neg_out = stb_neg_reg;
	assign o_valid_out = valid_reg;
	assign o_valid_oe = drive_reg;
	assign o_held_out = drive_reg;
	assign o_held_oe = drive_reg;
	// Receive path: two-stage synchronisers then strobe fall detect
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			d_s1_reg <= '0;
			d_s2_reg <= '0;
			inv_s1_reg <= '0;
			inv_s2_reg <= '0;
			par_s1_reg <= '0;
			par_s2_reg <= '0;
			sp_s1_reg <= '0;
			sp_s2_reg <= '0;
			sp_s3_reg <= '0;
			sn_s1_reg <= '0;
			sn_s2_reg <= '0;
			sn_s3_reg <= '0;
			misc_s1_reg <= '0;
			misc_s2_reg <= '0;
		end else begin
			d_s1_reg <= i_data_in;
			d_s2_reg <= d_s1_reg;
			inv_s1_reg <= i_inv_in;
			inv_s2_reg <= inv_s1_reg;
			par_s1_reg <= i_par_in;
			par_s2_reg <= par_s1_reg;
			sp_s1_reg <= i_stb_pos_in;
			sp_s2_reg <= sp_s1_reg;
			sp_s3_reg <= sp_s2_reg;
			sn_s1_reg <= i_stb_neg_in;
			sn_s2_reg <= sn_s1_reg;
			sn_s3_reg <= sn_s2_reg;
			misc_s1_reg <= {i_defer_in, i_dirty_in, i_hit_in, i_held_in, i_valid_in};
			misc_s2_reg <= misc_s1_reg;
		end
	end
	wire logic [GROUPS-1:0] stb_fall;
	assign stb_fall = (sp_s3_reg & ~sp_s2_reg) | (sn_s3_reg & ~sn_s2_reg);
	logic [DW-1:0] rx_data_reg;
	logic rx_valid_reg;
	logic [GROUPS-1:0] rx_err_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rx_data_reg <= '0;
			rx_valid_reg <= 1'b0;
			rx_err_reg <= '0;
		end else begin
			rx_valid_reg <= (&stb_fall) && misc_s2_reg[0] && !drive_reg;
			if (&stb_fall) begin
				rx_data_reg <= rx_word;
				rx_err_reg <= rx_par ^ par_s2_reg;
			end
		end
	end
	assign o_rx_data = rx_data_reg;
	assign o_rx_valid = rx_valid_reg;
	assign o_rx_par_err = rx_err_reg;
	// Snoop lines driven and sampled only at bus clock rise
	logic hit_drv_reg, dirty_drv_reg, hit_smp_reg, dirty_smp_reg, defer_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hit_drv_reg <= 1'b0;
			dirty_drv_reg <= 1'b0;
			hit_smp_reg <= 1'b0;
			dirty_smp_reg <= 1'b0;
			defer_reg <= 1'b0;
		end else if (bclk_rise) begin
			hit_drv_reg <= i_snoop_hit_req;
			dirty_drv_reg <= i_snoop_dirty_req;
			hit_smp_reg <= misc_s2_reg[2];
			dirty_smp_reg <= misc_s2_reg[3];
			defer_reg <= misc_s2_reg[4];
		end
	end
	assign o_hit_out = hit_drv_reg;
	assign o_hit_oe = hit_drv_reg;
	assign o_dirty_out = dirty_drv_reg;
	assign o_dirty_oe = dirty_drv_reg;
	assign o_snoop_hit = hit_smp_reg;
	assign o_snoop_dirty = dirty_smp_reg;
	assign o_snoop_stall = hit_smp_reg & dirty_smp_reg;
	assign o_defer = defer_reg;
	AST_RESET_RELEASE: assert property (@(posedge i_clk)
		i_rst ##1 i_rst |-> !o_data_oe && !o_held_oe && !o_valid_oe && !o_hit_oe && !o_dirty_oe)
		else $error("outputs not released under reset");
	AST_VALID_NEEDS_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
		o_valid_out |-> o_held_out && o_held_oe)
		else $error("valid without busy");
	AST_TAKE_VALID: assert property (@(posedge i_clk) disable iff (i_rst)
		take |=> o_valid_out)
		else $error("beat not marked valid");
	AST_PAR_OE: assert property (@(posedge i_clk) disable iff (i_rst)
		o_valid_out |-> o_data_oe)
		else $error("parity not driven with data");
	AST_STALL: assert property (@(posedge i_clk) disable iff (i_rst)
		bclk_rise |=> (o_snoop_stall == ($past(misc_s2_reg[2]) && $past(misc_s2_reg[3]))))
		else $error("stall does not follow both snoop lines");
	AST_SNOOP_EDGE: assert property (@(posedge i_clk) disable iff (i_rst)
		!$past(bclk_rise) |-> $stable(o_hit_out))
		else $error("snoop changed off edge");
	AST_PAR_EVEN: assert property (@(posedge i_clk) disable iff (i_rst)
		o_valid_out |-> (o_par_out == par_seen))
		else $error("parity wrong on driven beat");
	AST_GAP_IDLE: assert property (@(posedge i_clk) disable iff (i_rst)
		(st_reg == qp_bus_pkg::ST_GAP) |=> !o_held_out)
		else $error("busy after last");
endmodule

// ===== tb/bus_peer_model.sv
// Far-side bus agent: sends data beats, snoop results and defer
`timescale 1ns/1ps
module bus_peer_model (
	input wire logic i_clk,
	output logic [63:0] o_data,
	output logic [3:0] o_inv,
	output logic [3:0] o_par,
	output logic [3:0] o_pos,
	output logic [3:0] o_neg,
	output logic o_valid,
	output logic o_held,
	output logic o_hit,
	output logic o_dirty,
	output logic o_defer
);
	logic ph = 0;
	initial begin
		{o_data, o_inv, o_par, o_pos, o_neg} = '0;
		{o_valid, o_held, o_hit, o_dirty, o_defer} = '0;
	end
	task automatic snoop(input logic h, input logic dm, input logic df);
		@(posedge i_clk);
		#1 {o_hit, o_dirty} = {h, dm};
		o_defer = df;
	endtask
	// One beat; bad corrupts group 1 parity
	task automatic send(input logic [63:0] d, input logic bad);
		logic [63:0] w;
		logic [3:0] inv;
		logic [3:0] par;
		for (int g = 0; g < 4; g++) begin
			inv[g] = $countones(d[g*16+:16] ^ o_data[g*16+:16]) > 8;
			w[g*16+:16] = d[g*16+:16] ^ {16{inv[g]}};
			par[g] = ^{w[g*16+:16], inv[g]} ^ (bad && g == 1);
		end
		@(posedge i_clk);
		#1 {o_held, o_valid} = 2'b11;
		{o_data, o_inv, o_par} = {w, inv, par};
		if (ph) o_neg = 4'hf;
		else o_pos = 4'hf;
		#400 {o_pos, o_neg} = 8'h00;
		#400 {o_held, o_valid} = 2'b00;
		// Released lines fall back to the terminated idle level
		{o_data, o_inv, o_par} = '0;
		ph = !ph;
	endtask
endmodule

// ===== tb/quad_pumped_data_bus_phase_test.sv
// Self-checking bench for the data phase controller
`timescale 1ns/1ps
module quad_pumped_data_bus_phase_test;
	logic i_clk = 0, i_rst = 1, i_tx_valid = 0, i_tx_last = 0;
	logic i_snoop_hit_req = 0, i_snoop_dirty_req = 0;
	logic [63:0] i_tx_data = 0, o_rx_data, o_data_out, i_data_in, p_data, prev = 0;
	logic o_tx_ready, o_rx_valid, o_snoop_hit, o_snoop_dirty, o_snoop_stall, o_defer;
	logic o_bus_clk, o_data_oe, o_valid_out, o_valid_oe, o_held_out, o_held_oe;
	logic o_hit_out, o_hit_oe, o_dirty_out, o_dirty_oe, i_defer_in;
	logic i_valid_in, i_held_in, i_hit_in, i_dirty_in, p_valid, p_held, p_hit, p_dirty;
	logic [3:0] o_rx_par_err, o_inv_out, i_inv_in, o_par_out, i_par_in, p_inv, p_par;
	logic [3:0] o_stb_pos_out, o_stb_neg_out, i_stb_pos_in, i_stb_neg_in, p_pos, p_neg;
	logic [63:0] exp_q[$];
	int errors = 0, checks = 0;
	logic stb_ph = 0;
	always #50 i_clk = ~i_clk;
	assign i_data_in = o_data_oe ? o_data_out : p_data;
	assign i_inv_in = o_data_oe ? o_inv_out : p_inv;
	assign i_par_in = o_data_oe ? o_par_out : p_par;
	assign i_stb_pos_in = o_stb_pos_out | p_pos;
	assign i_stb_neg_in = o_stb_neg_out | p_neg;
	assign i_valid_in = (o_valid_oe & o_valid_out) | p_valid;
	assign i_held_in = (o_held_oe & o_held_out) | p_held;
	assign i_hit_in = (o_hit_oe & o_hit_out) | p_hit;
	assign i_dirty_in = (o_dirty_oe & o_dirty_out) | p_dirty;
	qp_bus_host uut (.i_clk, .i_rst, .i_tx_data, .i_tx_valid, .i_tx_last, .o_tx_ready,
		.o_rx_data, .o_rx_valid, .o_rx_par_err, .i_snoop_hit_req, .i_snoop_dirty_req,
		.o_snoop_hit, .o_snoop_dirty, .o_snoop_stall, .o_defer, .o_bus_clk, .o_data_out,
		.o_data_oe, .i_data_in, .o_inv_out, .i_inv_in, .o_par_out, .i_par_in, .o_stb_pos_out,
		.o_stb_neg_out, .i_stb_pos_in, .i_stb_neg_in, .o_valid_out, .o_valid_oe, .i_valid_in,
		.o_held_out, .o_held_oe, .i_held_in, .o_hit_out, .o_hit_oe, .i_hit_in, .o_dirty_out,
		.o_dirty_oe, .i_dirty_in, .i_defer_in);
	bus_peer_model p (.i_clk, .o_data(p_data), .o_inv(p_inv), .o_par(p_par), .o_pos(p_pos),
		.o_neg(p_neg), .o_valid(p_valid), .o_held(p_held), .o_hit(p_hit), .o_dirty(p_dirty),
		.o_defer(i_defer_in));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// Every driven beat is decoded back and judged on the wires
	always @(negedge i_clk) begin
		if (o_valid_out === 1'b1 && o_valid_oe === 1'b1 && exp_q.size() > 0) begin
			for (int g = 0; g < 4; g++) begin
				chk(o_data_out[g*16+:16] ^ {16{o_inv_out[g]}}, exp_q[0][g*16+:16]);
				chk(o_inv_out[g], $countones(exp_q[0][g*16+:16] ^ prev[g*16+:16]) > 8);
				chk(o_par_out[g], ^{o_data_out[g*16+:16], o_inv_out[g]});
			end
			chk(o_held_out & o_held_oe & o_data_oe, 1);
			chk({o_stb_pos_out, o_stb_neg_out}, stb_ph ? 8'h0f : 8'hf0);
			stb_ph = !stb_ph;
			prev = o_data_out;
			void'(exp_q.pop_front());
		end
	end
	task automatic tx_burst(input logic [63:0] a, b, c, e);
		logic [63:0] q[4];
		int n;
		q = '{a, b, c, e};
		for (int i = 0; i < 4; i++) begin
			@(posedge i_clk);
			#1 {i_tx_data, i_tx_valid, i_tx_last} = {q[i], 1'b1, i == 3};
			exp_q.push_back(q[i]);
			n = 0;
			do begin @(negedge i_clk); n++; end while (o_tx_ready !== 1'b1 && n < 40);
			chk(n < 40, 1);
		end
		@(posedge i_clk);
		#1 {i_tx_valid, i_tx_last} = 2'b00;
		repeat (12) @(negedge i_clk);
		chk(exp_q.size(), 0);
		chk(o_held_out & o_held_oe, 0);
	endtask
	task automatic rx_case(input logic [63:0] d, input logic bad);
		logic got;
		got = 0;
		fork p.send(d, bad); join_none
		repeat (30) begin
			@(negedge i_clk);
			if (o_rx_valid === 1'b1 && !got) begin
				got = 1;
				chk(o_rx_data, d);
				chk(o_rx_par_err, bad ? 4'h2 : 4'h0);
			end
		end
		chk(got, 1);
	endtask
	task automatic snoop_case;
		p.snoop(0, 0, 1);
		{i_snoop_hit_req, i_snoop_dirty_req} = 2'b11;
		repeat (12) @(negedge i_clk);
		chk({o_hit_out & o_hit_oe, o_dirty_out & o_dirty_oe, o_snoop_stall}, 3'b111);
		chk(o_defer, 1);
		@(posedge i_clk);
		#1 {i_snoop_hit_req, i_snoop_dirty_req} = 2'b10;
		repeat (12) @(negedge i_clk);
		chk({o_snoop_hit, o_snoop_dirty, o_snoop_stall}, 3'b100);
	endtask
	task automatic reset_case;
		@(posedge i_clk);
		#1 i_rst = 1;
		repeat (8) @(negedge i_clk);
		chk({o_data_oe, o_valid_oe, o_held_oe, o_hit_oe, o_dirty_oe}, 0);
		chk({o_stb_pos_out, o_stb_neg_out}, 0);
		@(posedge i_clk);
		#1 {i_rst, i_snoop_hit_req, i_snoop_dirty_req} = 3'b000;
		prev = 0;
		stb_ph = 0;
		// Bus clock restarts high for two beats, then low for two
		for (int k = 0; k < 8; k++) begin
			@(negedge i_clk);
			chk(o_bus_clk, (k % 4) < 2);
		end
	endtask
	initial begin
		repeat (20) @(posedge i_clk);
		#1 i_rst = 0;
		rx_case(64'hffff_ffff_ffff_ffff, 0);
		rx_case(64'h0123_fedc_00ff_a5a5, 0);
		rx_case(64'h5a5a_0f0f_ffff_0000, 1);
		tx_burst(64'hffff_ffff_ffff_ffff, 64'h00ff_0000_ffff_0f0f, 64'h0000_ff00_1ff0_0001, 64'h0);
		tx_burst(64'h8000_7fff_0000_00ff, 64'h7fff_8000_01ff_0000, 64'h0, 64'h0001_0001_0001_0001);
		snoop_case;
		reset_case;
		tx_burst(64'h1, 64'h2, 64'hffff_0000_ffff_0000, 64'h0000_ffff_0000_ffff);
		wrap_up;
	end
	initial begin
		#200000;
		errors++;
		wrap_up;
	end
endmodule
